//--- design/periph_lock_defs.svh
`ifndef PERIPH_LOCK_DEFS_SVH
`define PERIPH_LOCK_DEFS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PERIPH_CFG_ADDR 32'h01B3F000
`define DEVICE_STATUS_ADDR 32'h01B3F004
`define CONFIG_LOCK_ADDR 32'h01B3F018

// ****************************************************************
// Key, reset values and counts
// ****************************************************************
`define UNLOCK_KEY 32'h10C0010C
`define LOCK_STATE_RESET 1'b1
`define PERIPH_CFG_RESET 32'h00000000
`define SETTLE_CYCLES 8'h80
`define STRAP_SYNC_CYCLES 2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define LOCK_STATE_BIT 0
`define DS_MAC_BIT 11
`define DS_HP_WIDTH_BIT 10
`define DS_EEAI_BIT 9
`define DS_PCI_BIT 8
`define DS_CLKMUL_HI 6
`define DS_CLKMUL_LO 5
`define DS_ENDIAN_BIT 4
`define DS_BOOT_HI 3
`define DS_BOOT_LO 2
`define DS_EMCLK_HI 1
`define DS_EMCLK_LO 0

`endif

//--- design/periph_lock_pkg.sv
// ****************************************************************
// Shared types
// ****************************************************************
`default_nettype none
package periph_lock_pkg;

  // Reset-time selections sampled from the strap pins.
  typedef struct packed {
    logic ether_mac_on;
    logic host_port_width;
    logic pci_eeprom_autoinit;
    logic pci_select;
    logic [1:0] cpu_clock_multiplier;
    logic endian_select;
    logic [1:0] boot_source;
    logic [1:0] ext_mem_clock_select;
  } strap_s;

  // One register bus request.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // Strap capture sequence after reset release.
  typedef enum logic [1:0] {
    CAP_SYNC,
    CAP_TAKE,
    CAP_DONE
  } cap_state_e;

endpackage : periph_lock_pkg

`default_nettype wire

//--- design/periph_config_lock_and_device_status.sv
// Summary of operation
// - Reserved bits of lock and status registers read zero, ignore writes.
// - While locked, configuration register writes leave its contents unchanged.
// - Configuration reads always return contents; lock bit reads 0 when unlocked.
// - Writing exactly the key to the lock register unlocks and clears lock bit.
// - Any configuration register write relocks it.
// - Status bit 11 shows Ethernet MAC enable, default 0.
// - Status bit 10 shows host port width, 0 is 16-bit.
// - Status bit 9 shows PCI EEPROM auto-initialisation, default 0.
// - Status bit 8 shows PCI versus host port group select, default 0.
// - Status bits 6:5 show CPU clock multiplier, default bypass.
// - Status bit 4 shows byte order, 1 little endian default.
// - Status bits 3:2 show boot source, default no boot.
// - Status bits 1:0 show external memory clock source, default input clock.
// - An enable bit may turn on only while unlocked.
`timescale 1ns/1ps
`default_nettype none
`include "periph_lock_defs.svh"

module periph_config_lock_and_device_status
  import periph_lock_pkg::*;
(
  input wire logic clk, // 20 MHz CPU-side clock.
  input wire logic reset, // Asynchronous, active high.
  input wire bus_req_s bus_req, // Address, write data and strobes.
  input wire strap_s strap_pins, // Reset-time selection pins.
  output logic [31:0] rdata, // Read data, valid the cycle after a read.
  output logic [31:0] periph_enable, // Peripheral enable configuration.
  output logic [31:0] periph_ready, // Enabled and settled peripherals.
  output logic lock_state, // High while configuration is locked.
  output strap_s device_status // Captured reset-time selections.
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Decoded strobes; the master never waits, so all are single cycle.
  logic hit_cfg;
  logic hit_status;
  logic hit_lock;
  logic cfg_write;
  logic lock_write;
  logic key_match;
  logic cfg_taken;

  assign hit_cfg = (bus_req.addr == `PERIPH_CFG_ADDR);
  assign hit_status = (bus_req.addr == `DEVICE_STATUS_ADDR);
  assign hit_lock = (bus_req.addr == `CONFIG_LOCK_ADDR);
  assign cfg_write = bus_req.wr && hit_cfg;
  assign lock_write = bus_req.wr && hit_lock;
  assign key_match = (bus_req.wdata == `UNLOCK_KEY);
  // A configuration write only lands while the lock is open.
  assign cfg_taken = cfg_write && !lock_state;

  // ****************************************************************
  // Lock state
  // ****************************************************************

  // Only the full 32-bit key opens the lock; the whole word is compared so
  // a stray partial pattern can never unlock by accident.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_state <= `LOCK_STATE_RESET;
    end else if (cfg_write) begin
      lock_state <= 1'b1;
    end else if (lock_write && key_match) begin
      lock_state <= 1'b0;
    end
  end

  // ****************************************************************
  // Peripheral enable configuration
  // ****************************************************************

  // The register holds software's word; its field meaning lives elsewhere.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periph_enable <= `PERIPH_CFG_RESET;
    end else if (cfg_taken) begin
      periph_enable <= bus_req.wdata;
    end
  end

  // ****************************************************************
  // Settling after an enable change
  // ****************************************************************

  // Counts the cycles since the last accepted write. Software must still
  // wait on its own; this flag only tells logic nearby when it is safe.
  logic [7:0] settle_count;
  logic settled;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settle_count <= 8'h00;
    end else if (cfg_taken) begin
      settle_count <= 8'h00;
    end else if (settle_count != `SETTLE_CYCLES) begin
      settle_count <= settle_count + 8'h01;
    end
  end

  // The count saturates at the settle time and then holds.
  assign settled = (settle_count == `SETTLE_CYCLES);

  // Per-peripheral ready flags, each registered so the output is a flop.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_ready
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          periph_ready[gi] <= 1'b0;
        end else if (cfg_taken) begin
          periph_ready[gi] <= 1'b0;
        end else begin
          periph_ready[gi] <= periph_enable[gi] && settled;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Strap synchroniser and capture
  // ****************************************************************

  // Straps come from pins and pass two flops; only the second is read.
  strap_s strap_meta;
  strap_s strap_sync;
  cap_state_e cap_state;
  logic [1:0] sync_count;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= strap_pins;
      strap_sync <= strap_meta;
    end
  end

  // Waits for the synchroniser to fill before taking a single sample.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_state <= CAP_SYNC;
      sync_count <= 2'h0;
    end else begin
      case (cap_state)
        CAP_SYNC: begin
          sync_count <= sync_count + 2'h1;
          if (sync_count == `STRAP_SYNC_CYCLES - 2'h1) begin
            cap_state <= CAP_TAKE;
          end
        end
        CAP_TAKE: begin
          cap_state <= CAP_DONE;
        end
        CAP_DONE: begin
          cap_state <= CAP_DONE;
        end
        default: begin
          cap_state <= CAP_SYNC;
        end
      endcase
    end
  end

  // Before capture the documented defaults show, little endian included.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      device_status <= '0;
      device_status.endian_select <= 1'b1;
    end else if (cap_state == CAP_TAKE) begin
      device_status <= strap_sync;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Status word assembled at fixed bit positions; everything else is zero.
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h00000000;
    status_word[`DS_MAC_BIT] = device_status.ether_mac_on;
    status_word[`DS_HP_WIDTH_BIT] = device_status.host_port_width;
    status_word[`DS_EEAI_BIT] = device_status.pci_eeprom_autoinit;
    status_word[`DS_PCI_BIT] = device_status.pci_select;
    status_word[`DS_CLKMUL_HI:`DS_CLKMUL_LO] = device_status.cpu_clock_multiplier;
    status_word[`DS_ENDIAN_BIT] = device_status.endian_select;
    status_word[`DS_BOOT_HI:`DS_BOOT_LO] = device_status.boot_source;
    status_word[`DS_EMCLK_HI:`DS_EMCLK_LO] = device_status.ext_mem_clock_select;
  end

  // Read data stand for one cycle only and are zero otherwise, so a
  // stale word can never be mistaken for a fresh answer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (bus_req.rd) begin
      if (hit_cfg) begin
        rdata <= periph_enable;
      end else if (hit_status) begin
        rdata <= status_word;
      end else if (hit_lock) begin
        rdata <= {31'h00000000, lock_state};
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_key_write;
    lock_write && key_match;
  endsequence

  sequence s_cfg_accept;
    cfg_taken;
  endsequence

  sequence s_quiet_8;
    (periph_ready == 32'h00000000) [*8];
  endsequence

  a_key_unlocks: assert property (s_key_write |=> !lock_state)
    else $error("key write did not unlock");

  a_cfg_relocks: assert property (cfg_write |=> lock_state)
    else $error("configuration write did not relock");

  a_locked_hold: assert property (
    (cfg_write && lock_state) |=> (periph_enable == $past(periph_enable)))
    else $error("locked write changed configuration");

  a_badkey_hold: assert property (
    (lock_write && !key_match) |=> (lock_state == $past(lock_state)))
    else $error("non-key write changed lock state");

  a_enable_unlocked: assert property (
    ((periph_enable & ~$past(periph_enable)) != 32'h00000000) |-> !$past(lock_state))
    else $error("enable bit set while locked");

  a_cfg_readback: assert property (
    (bus_req.rd && hit_cfg) |=> (rdata == $past(periph_enable)))
    else $error("configuration read mismatch");

  a_lock_readback: assert property (
    (bus_req.rd && hit_lock) |=> (rdata == {31'h00000000, $past(lock_state)}))
    else $error("lock register read mismatch");

  a_status_reserved: assert property (
    (bus_req.rd && hit_status) |=> (rdata[31:12] == 20'h00000 && rdata[7] == 1'b0))
    else $error("status reserved bits not zero");

  a_status_stable: assert property (
    (cap_state == CAP_DONE && $past(cap_state) == CAP_DONE) |-> $stable(device_status))
    else $error("status changed after capture");

  a_capture_timely: assert property (
    $fell(reset) |-> ##[1:4] (cap_state == CAP_DONE))
    else $error("status capture late");

  a_settle_quiet: assert property (s_cfg_accept |=> s_quiet_8)
    else $error("peripheral ready too early");

  a_rdata_idle: assert property (!$past(bus_req.rd) |-> (rdata == 32'h00000000))
    else $error("read data outside answer cycle");

endmodule : periph_config_lock_and_device_status

`default_nettype wire

//--- test/periph_config_lock_and_device_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "periph_lock_defs.svh"

module periph_config_lock_and_device_status_tb
  import periph_lock_pkg::*;
;
  logic clk;
  logic reset;
  bus_req_s bus_req;
  strap_s strap_pins;
  logic [31:0] rdata;
  logic [31:0] periph_enable;
  logic [31:0] periph_ready;
  logic lock_state;
  strap_s device_status;
  int n_fail;
  int checks;
  int cycles;
  logic [31:0] got;
  strap_s patterns [4] = '{11'h000, 11'h7FF, 11'b1010_01_0_01_10, 11'b0101_10_1_11_01};

  // ****************************************************************
  // Clock, instance and hang guard
  // ****************************************************************
  // The clock runs at 20 MHz.
  initial clk = 1'b0;
  always #25 clk = ~clk;

  periph_config_lock_and_device_status dut (
    .clk(clk),
    .reset(reset),
    .bus_req(bus_req),
    .strap_pins(strap_pins),
    .rdata(rdata),
    .periph_enable(periph_enable),
    .periph_ready(periph_ready),
    .lock_state(lock_state),
    .device_status(device_status)
  );

  // The whole run needs under a thousand cycles, so a stuck bus ends it here.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Counts one comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One-cycle write strobe; the slave never stalls.
  task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
    @(posedge clk);
    bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : bus_write

  // Read data is only valid in the cycle after the strobe edge.
  task automatic bus_read(input logic [31:0] addr, output logic [31:0] data);
    @(posedge clk);
    bus_req <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 data = rdata;
  endtask : bus_read

  // Expected status word: bit 7 and bits 31:12 are reserved zeros.
  function automatic logic [31:0] status_word(input strap_s s);
    return {20'h0, s[10:7], 1'b0, s[6:0]};
  endfunction : status_word

  // Straps are held steady from reset onwards, as the capture needs.
  // Reset is raised on a clock edge so every input moves with the clock.
  task automatic do_reset(input strap_s s);
    @(posedge clk);
    reset <= 1'b1;
    strap_pins <= s;
    bus_req <= '0;
    repeat (9) @(posedge clk);
    #1 check("status in reset", 32'h10, {21'h0, device_status});
    @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : do_reset

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every field code except boot source 2'b10 is captured and cannot be overwritten.
  task automatic test_status();
    foreach (patterns[i]) begin
      do_reset(patterns[i]);
      check("status port", {21'h0, patterns[i]}, {21'h0, device_status});
      bus_read(`DEVICE_STATUS_ADDR, got);
      check("status word", status_word(patterns[i]), got);
      bus_write(`DEVICE_STATUS_ADDR, 32'hFFFFFFFF);
      bus_read(`DEVICE_STATUS_ADDR, got);
      check("status after write", status_word(patterns[i]), got);
    end
    $display("test status done");
  endtask : test_status

  // Locked writes, a wrong key, the key and the relock.
  task automatic test_lock();
    bus_read(`CONFIG_LOCK_ADDR, got);
    check("lock read", 32'h1, got);
    bus_write(`PERIPH_CFG_ADDR, 32'h000000A5);
    check("enable while locked", 32'h0, periph_enable);
    bus_read(`PERIPH_CFG_ADDR, got);
    check("config read locked", 32'h0, got);
    bus_write(`CONFIG_LOCK_ADDR, 32'h10C0010D);
    check("lock after bad key", 32'h1, {31'h0, lock_state});
    bus_write(`CONFIG_LOCK_ADDR, `UNLOCK_KEY);
    check("lock after key", 32'h0, {31'h0, lock_state});
    bus_read(`CONFIG_LOCK_ADDR, got);
    check("lock read unlocked", 32'h0, got);
    bus_write(`CONFIG_LOCK_ADDR, 32'h00000000);
    check("unlocked after bad key", 32'h0, {31'h0, lock_state});
    bus_write(`PERIPH_CFG_ADDR, 32'h0000005A);
    check("enable after key", 32'h5A, periph_enable);
    check("relock", 32'h1, {31'h0, lock_state});
    bus_write(`PERIPH_CFG_ADDR, 32'h000000FF);
    bus_read(`PERIPH_CFG_ADDR, got);
    check("config after relock", 32'h5A, got);
    bus_read(32'h01B3F008, got);
    check("unmapped read", 32'h0, got);
    $display("test lock done");
  endtask : test_lock

  // Enabled bits report ready only after the settle time.
  task automatic test_ready();
    bus_write(`CONFIG_LOCK_ADDR, `UNLOCK_KEY);
    bus_write(`PERIPH_CFG_ADDR, 32'h000000FF);
    bus_read(`PERIPH_CFG_ADDR, got);
    check("config readback", 32'hFF, got);
    // no peripheral access
    // The wait is timed from the write edge: ready must still be low at 128.
    repeat (126) @(posedge clk);
    #1 check("ready early", 32'h0, periph_ready);
    repeat (2) @(posedge clk);
    #1 check("ready late", 32'hFF, periph_ready);
    $display("test ready done");
  endtask : test_ready

  // ****************************************************************
  // Main sequence and verdict
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Inputs get values at time zero before the first reset.
  initial begin
    n_fail = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    bus_req = '0;
    strap_pins = '0;
    test_status();
    test_lock();
    test_ready();
    complete_run();
  end
endmodule : periph_config_lock_and_device_status_tb

`default_nettype wire
